/* design/rtca_defines.svh */
// register offsets, field positions, reset values and timing counts for the rtc alarm block
`ifndef RTCA_DEFINES_SVH
`define RTCA_DEFINES_SVH
`define RTCA_OFF_SEC_ALM   4'h0
`define RTCA_OFF_MIN_ALM   4'h1
`define RTCA_OFF_HOUR_ALM  4'h2
`define RTCA_OFF_WDAY_ALM  4'h3
`define RTCA_OFF_DATE_ALM  4'h4
`define RTCA_OFF_MON_ALM   4'h5
`define RTCA_OFF_FLAG_CTL  4'h6
`define RTCA_OFF_PER_CTL   4'h7
`define RTCA_OFF_SUBSEC    4'h8
`define RTCA_OFF_SEC_CNT   4'h9
`define RTCA_BIT_ENB       7
`define RTCA_BIT_CF        7
`define RTCA_BIT_CIE       4
`define RTCA_BIT_AIE       3
`define RTCA_BIT_AF        0
`define RTCA_BIT_PEF       7
`define RTCA_BIT_RUN       3
`define RTCA_BIT_ADJ       2
`define RTCA_BIT_DIVRST    1
`define RTCA_BIT_START     0
`define RTCA_MASK_SEC      8'h7f
`define RTCA_MASK_HOUR     8'h3f
`define RTCA_MASK_WDAY     8'h07
`define RTCA_MASK_DATE     8'h3f
`define RTCA_MASK_MON      8'h1f
`define RTCA_MASK_FCTL     8'h99
`define RTCA_RST_FCTL      8'h00
`define RTCA_RST_PCTL      8'h09
`define RTCA_MAN_PCTL_KEEP 8'h09
`define RTCA_SEC_29        7'h29
`define RTCA_SEC_59        7'h59
`define RTCA_BCD_NINE      4'h9
`define RTCA_BCD_FIVE      3'h5
`define RTCA_SUB_TOP       7'h7f
// 128 prescaler ticks per second; one tick = 1/128 s
`define RTCA_TICK_HZ       128
`define RTCA_CLK_HZ        100000000
`endif

/* design/rtca_pkg.sv */
// types shared by the rtc alarm block
package rtca_pkg;
  typedef logic [7:0] rtca_byte_t;
  typedef logic [3:0] rtca_addr_t;
  typedef enum logic [1:0]
  {
    RTCA_RST_NONE   = 2'b00,
    RTCA_RST_POWER  = 2'b01,
    RTCA_RST_MANUAL = 2'b10
  } rtca_rst_kind_t;
endpackage : rtca_pkg

/* design/rtca_match.sv */
// one alarm field comparator: enabled fields must equal their counter
`include "rtca_defines.svh"
module rtca_match
  import rtca_pkg::*;
(
  // alarm and counter
  input  wire rtca_byte_t i_alarm,
  input  wire rtca_byte_t i_count,
  input  wire rtca_byte_t i_mask,
  // result
  output logic            o_hit,
  output logic            o_enabled
);
  always_comb
  begin
    o_enabled = i_alarm[`RTCA_BIT_ENB];
    o_hit     = ~o_enabled | ((i_alarm & i_mask) == (i_count & i_mask));
  end
endmodule : rtca_match

/* design/rtca_core.sv */
// rtc alarm compare, flag control, periodic tick, prescaler and seconds rounding
//
// The address map and the plain strobed port are this design's own decisions.
`include "rtca_defines.svh"
// Summary of operation
// - bit 7 of each alarm register enables comparing that field.
// - alarm matches only when all enabled fields equal their counters.
// - seconds and minutes alarms are bcd, tens bits 6-4, range 00-59.
// - hours alarm bcd tens bits 5-4; bit 6 reads zero.
// - weekday alarm bits 2-0, sunday 0 to saturday 6; bits 6-3 read zero.
// - date alarm bcd tens bits 5-4, 01-31; bit 6 reads zero.
// - month alarm bcd tens bit 4, 01-12; bits 6-5 read zero.
// - power-on clears compare enables; other alarm bits kept through all resets.
// - flag control clears at power-on; manual reset keeps carry flag.
// - carry flag sets on each sub-second or seconds count-up.
// - writing zero clears the carry flag; software initialises it.
// - carry irq enable bit 4 gates carry flag onto carry request.
// - alarm irq enable bit 3 gates alarm flag onto alarm request.
// - alarm flag bit 0 sets when enabled fields match counters.
// - writing zero clears alarm flag, writing one leaves it.
// - flag control bits 6,5,2,1 read zero and ignore writes.
// - period control resets to 09; manual reset keeps run and start.
// - periodic flag sets each selected interval, requests irq, cleared by zero.
// - rate select zero disables periodic flag setting.
// - codes 1..7 give 1/256,1/64,1/16,1/4,1/2,1,2 seconds.
// - adjust rounds seconds to minute boundary, clears divider, reads zero.
// - divider reset clears prescaler and sub-second counter, reads zero.
// - start bit halts or runs the seconds and calendar counters, the sub-second counter keeps running; clearing run bit stops the oscillator.
module rtca_core
  import rtca_pkg::*;
#(
  parameter int unsigned TICK_DIV = `RTCA_CLK_HZ / `RTCA_TICK_HZ
)
(
  // clock, reset and enable
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  input  wire rtca_pkg::rtca_rst_kind_t i_rst_kind,
  // register port
  input  wire rtca_pkg::rtca_addr_t i_addr,
  input  wire rtca_pkg::rtca_byte_t i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output rtca_pkg::rtca_byte_t     o_rdata,
  // calendar counters from the time-keeping logic
  input  wire rtca_pkg::rtca_byte_t i_min_cnt,
  input  wire rtca_pkg::rtca_byte_t i_hour_cnt,
  input  wire rtca_pkg::rtca_byte_t i_wday_cnt,
  input  wire rtca_pkg::rtca_byte_t i_date_cnt,
  input  wire rtca_pkg::rtca_byte_t i_mon_cnt,
  // controls to and events for the time-keeping logic
  output logic                     o_sec_carry,
  output logic                     o_min_inc,
  output logic                     o_count_run,
  output logic                     o_osc_run,
  // interrupt requests
  output logic                     o_carry_irq,
  output logic                     o_alarm_irq,
  output logic                     o_period_irq
);
  import rtca_pkg::*;

  typedef struct packed
  {
    rtca_byte_t        alm_sec;
    rtca_byte_t        alm_min;
    rtca_byte_t        alm_hour;
    rtca_byte_t        alm_wday;
    rtca_byte_t        alm_date;
    rtca_byte_t        alm_mon;
    rtca_byte_t        fctl;
    rtca_byte_t        pctl;
    logic [31:0]       pre;
    logic [6:0]        sub;
    logic [6:0]        sec;
    logic              sec_carry;
    logic              min_inc;
    logic              upd;
    logic              match_prev;
    rtca_byte_t        rdata;
    logic              carry_irq;
    logic              alarm_irq;
    logic              period_irq;
  } rtca_state_t;

  rtca_state_t state_q;
  rtca_state_t state_d;
  rtca_byte_t  alarm_v [6];
  rtca_byte_t  count_v [6];
  rtca_byte_t  mask_v  [6];
  logic [5:0]  hit_v;
  logic [5:0]  en_v;
  logic        match_all;

  always_comb
  begin
    alarm_v[0] = state_q.alm_sec;
    alarm_v[1] = state_q.alm_min;
    alarm_v[2] = state_q.alm_hour;
    alarm_v[3] = state_q.alm_wday;
    alarm_v[4] = state_q.alm_date;
    alarm_v[5] = state_q.alm_mon;
    count_v[0] = {1'b0, state_q.sec};
    count_v[1] = i_min_cnt;
    count_v[2] = i_hour_cnt;
    count_v[3] = i_wday_cnt;
    count_v[4] = i_date_cnt;
    count_v[5] = i_mon_cnt;
    mask_v[0]  = `RTCA_MASK_SEC;
    mask_v[1]  = `RTCA_MASK_SEC;
    mask_v[2]  = `RTCA_MASK_HOUR;
    mask_v[3]  = `RTCA_MASK_WDAY;
    mask_v[4]  = `RTCA_MASK_DATE;
    mask_v[5]  = `RTCA_MASK_MON;
  end

  for (genvar g = 0; g < 6; g++)
  begin : g_cmp
    rtca_match u_match
    (
      .i_alarm   (alarm_v[g]),
      .i_count   (count_v[g]),
      .i_mask    (mask_v[g]),
      .o_hit     (hit_v[g]),
      .o_enabled (en_v[g])
    );
  end

  // an alarm with no enabled field never fires
  assign match_all = (&hit_v) & (|en_v);

  function automatic logic [6:0] bcd_sec_inc(input logic [6:0] s);
    logic [6:0] r;
    r = s;
    if (s[3:0] == `RTCA_BCD_NINE)
    begin
      r[3:0] = 4'h0;
      r[6:4] = (s[6:4] == `RTCA_BCD_FIVE) ? 3'h0 : s[6:4] + 3'h1;
    end
    else
    begin
      r[3:0] = s[3:0] + 4'h1;
    end
    return r;
  endfunction : bcd_sec_inc

  logic        tick;
  logic        sub_roll;
  logic        per_tick;
  logic        wr_fctl;
  logic        wr_pctl;
  logic [7:0]  sub_next;
  logic [7:0]  sub_rise;

  always_comb
  begin
    state_d = state_q;
    state_d.sec_carry = 1'b0;
    state_d.min_inc   = 1'b0;
    state_d.upd       = 1'b0;
    wr_fctl = i_wr && (i_addr == `RTCA_OFF_FLAG_CTL);
    wr_pctl = i_wr && (i_addr == `RTCA_OFF_PER_CTL);
    tick    = 1'b0;
    // oscillator stopped freezes the prescaler and everything behind it, but rate code 1 keeps setting the flag if pre stopped at TICK_DIV / 2 - 1
    if (state_q.pctl[`RTCA_BIT_RUN])
    begin
      if (state_q.pre == TICK_DIV - 1)
      begin
        state_d.pre = '0;
        tick        = 1'b1;
      end
      else
      begin
        state_d.pre = state_q.pre + 32'd1;
      end
    end
    sub_next = {1'b0, state_q.sub} + 8'h01;
    sub_rise = sub_next & ~{1'b0, state_q.sub};
    sub_roll = tick && (state_q.sub == `RTCA_SUB_TOP);
    if (tick)
    begin
      state_d.sub = sub_next[6:0];
    end
    // rate codes pick a sub-counter bit: 1/256 uses both prescaler halves
    case (state_q.pctl[6:4])
      3'h1: per_tick = tick || (state_q.pre == TICK_DIV / 2 - 1);
      3'h2: per_tick = tick && sub_rise[0];
      3'h3: per_tick = tick && sub_rise[2];
      3'h4: per_tick = tick && sub_rise[4];
      3'h5: per_tick = tick && sub_rise[5];
      3'h6: per_tick = sub_roll;
      3'h7: per_tick = sub_roll && state_q.sec[0];
      default: per_tick = 1'b0;
    endcase
    if (sub_roll && state_q.pctl[`RTCA_BIT_START])
    begin
      state_d.sec       = bcd_sec_inc(state_q.sec);
      state_d.sec_carry = 1'b1;
      state_d.upd       = 1'b1;
      state_d.min_inc   = (state_q.sec == `RTCA_SEC_59);
    end
    // register writes
    if (i_wr)
    begin
      if (i_addr == `RTCA_OFF_SEC_ALM)
        state_d.alm_sec = i_wdata & (`RTCA_MASK_SEC | 8'h80);
      else if (i_addr == `RTCA_OFF_MIN_ALM)
        state_d.alm_min = i_wdata & (`RTCA_MASK_SEC | 8'h80);
      else if (i_addr == `RTCA_OFF_HOUR_ALM)
        state_d.alm_hour = i_wdata & (`RTCA_MASK_HOUR | 8'h80);
      else if (i_addr == `RTCA_OFF_WDAY_ALM)
        state_d.alm_wday = i_wdata & (`RTCA_MASK_WDAY | 8'h80);
      else if (i_addr == `RTCA_OFF_DATE_ALM)
        state_d.alm_date = i_wdata & (`RTCA_MASK_DATE | 8'h80);
      else if (i_addr == `RTCA_OFF_MON_ALM)
        state_d.alm_mon = i_wdata & (`RTCA_MASK_MON | 8'h80);
      else if (i_addr == `RTCA_OFF_SEC_CNT)
        state_d.sec = i_wdata[6:0];
    end
    if (wr_fctl)
    begin
      state_d.fctl[`RTCA_BIT_CIE] = i_wdata[`RTCA_BIT_CIE];
      state_d.fctl[`RTCA_BIT_AIE] = i_wdata[`RTCA_BIT_AIE];
      // flags: a written zero clears, a one keeps
      state_d.fctl[`RTCA_BIT_CF] = state_q.fctl[`RTCA_BIT_CF] & i_wdata[`RTCA_BIT_CF];
      state_d.fctl[`RTCA_BIT_AF] = state_q.fctl[`RTCA_BIT_AF] & i_wdata[`RTCA_BIT_AF];
    end
    if (wr_pctl)
    begin
      state_d.pctl = i_wdata & 8'hf9;
      state_d.pctl[`RTCA_BIT_PEF] = state_q.pctl[`RTCA_BIT_PEF] & i_wdata[`RTCA_BIT_PEF];
      if (i_wdata[`RTCA_BIT_DIVRST] || i_wdata[`RTCA_BIT_ADJ])
      begin
        state_d.pre = '0;
        state_d.sub = '0;
      end
      if (i_wdata[`RTCA_BIT_ADJ])
      begin
        state_d.sec     = '0;
        state_d.upd     = 1'b1;
        state_d.min_inc = (state_q.sec > `RTCA_SEC_29);
      end
    end
    // hardware set wins over a simultaneous software clear
    if (tick || sub_roll)
      state_d.fctl[`RTCA_BIT_CF] = 1'b1;
    if (per_tick)
      state_d.pctl[`RTCA_BIT_PEF] = 1'b1;
    // counters settle one cycle after the update, so look after it
    state_d.match_prev = match_all;
    if (match_all && !state_q.match_prev)
      state_d.fctl[`RTCA_BIT_AF] = 1'b1;
    state_d.fctl = state_d.fctl & `RTCA_MASK_FCTL;
    // read data, one cycle later
    state_d.rdata = '0;
    if (i_rd)
    begin
      if (i_addr == `RTCA_OFF_SEC_ALM)
        state_d.rdata = state_q.alm_sec;
      else if (i_addr == `RTCA_OFF_MIN_ALM)
        state_d.rdata = state_q.alm_min;
      else if (i_addr == `RTCA_OFF_HOUR_ALM)
        state_d.rdata = state_q.alm_hour;
      else if (i_addr == `RTCA_OFF_WDAY_ALM)
        state_d.rdata = state_q.alm_wday;
      else if (i_addr == `RTCA_OFF_DATE_ALM)
        state_d.rdata = state_q.alm_date;
      else if (i_addr == `RTCA_OFF_MON_ALM)
        state_d.rdata = state_q.alm_mon;
      else if (i_addr == `RTCA_OFF_FLAG_CTL)
        state_d.rdata = state_q.fctl;
      else if (i_addr == `RTCA_OFF_PER_CTL)
        state_d.rdata = state_q.pctl & 8'hf9;
      else if (i_addr == `RTCA_OFF_SUBSEC)
        state_d.rdata = {1'b0, state_q.sub};
      else if (i_addr == `RTCA_OFF_SEC_CNT)
        state_d.rdata = {1'b0, state_q.sec};
    end
    state_d.carry_irq  = state_d.fctl[`RTCA_BIT_CF] & state_d.fctl[`RTCA_BIT_CIE];
    state_d.alarm_irq  = state_d.fctl[`RTCA_BIT_AF] & state_d.fctl[`RTCA_BIT_AIE];
    state_d.period_irq = state_d.pctl[`RTCA_BIT_PEF];
  end

  // reset kind is sampled with the reset itself; alarm values survive every reset, power-on clears their enables
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q.sec_carry  <= 1'b0;
      state_q.min_inc    <= 1'b0;
      state_q.upd        <= 1'b0;
      // a match held through reset must not fire again without a counter change
      state_q.match_prev <= 1'b1;
      state_q.rdata      <= '0;
      if (i_rst_kind == RTCA_RST_POWER)
      begin
        state_q.carry_irq  <= 1'b0;
        state_q.alarm_irq  <= 1'b0;
        state_q.period_irq <= 1'b0;
        state_q.alm_sec[`RTCA_BIT_ENB]  <= 1'b0;
        state_q.alm_min[`RTCA_BIT_ENB]  <= 1'b0;
        state_q.alm_hour[`RTCA_BIT_ENB] <= 1'b0;
        state_q.alm_wday[`RTCA_BIT_ENB] <= 1'b0;
        state_q.alm_date[`RTCA_BIT_ENB] <= 1'b0;
        state_q.alm_mon[`RTCA_BIT_ENB]  <= 1'b0;
        state_q.fctl <= `RTCA_RST_FCTL;
        state_q.pctl <= `RTCA_RST_PCTL;
      end
      else if (i_rst_kind == RTCA_RST_MANUAL)
      begin
        // enables and the periodic flag are cleared, so every request drops
        state_q.carry_irq  <= 1'b0;
        state_q.alarm_irq  <= 1'b0;
        state_q.period_irq <= 1'b0;
        state_q.fctl <= state_q.fctl & (8'h01 << `RTCA_BIT_CF);
        state_q.pctl <= (state_q.pctl & `RTCA_MAN_PCTL_KEEP)
                      | (`RTCA_RST_PCTL & ~`RTCA_MAN_PCTL_KEEP);
      end
    end
    else if (i_ce)
    begin
      state_q <= state_d;
    end
  end

  assign o_rdata      = state_q.rdata;
  assign o_sec_carry  = state_q.sec_carry;
  assign o_min_inc    = state_q.min_inc;
  assign o_count_run  = state_q.pctl[`RTCA_BIT_START];
  assign o_osc_run    = state_q.pctl[`RTCA_BIT_RUN];
  assign o_carry_irq  = state_q.carry_irq;
  assign o_alarm_irq  = state_q.alarm_irq;
  assign o_period_irq = state_q.period_irq;

  a_irq_level_tie : assert property (@(posedge i_clk) disable iff (i_rst)
    o_alarm_irq == (state_q.fctl[`RTCA_BIT_AF] && state_q.fctl[`RTCA_BIT_AIE]))
    else $error("alarm request does not follow flag and enable");
  a_af_clear_zero : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_wr && i_addr == `RTCA_OFF_FLAG_CTL && i_wdata[`RTCA_BIT_AF]
     && !state_q.fctl[`RTCA_BIT_AF] && !(match_all && !state_q.match_prev))
    |=> !state_q.fctl[`RTCA_BIT_AF])
    else $error("writing one set the alarm flag");
  a_af_on_match : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && match_all && !state_q.match_prev) |=> state_q.fctl[`RTCA_BIT_AF])
    else $error("alarm flag missed a match");
  a_no_enable_quiet : assert property (@(posedge i_clk) disable iff (i_rst)
    (en_v == 6'h00) |-> !match_all)
    else $error("match with no enabled field");
  a_cf_on_roll : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && tick) |=> state_q.fctl[`RTCA_BIT_CF])
    else $error("carry flag not set on count-up");
  a_rsv_read_zero : assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q.fctl & ~`RTCA_MASK_FCTL) == 8'h00)
    else $error("reserved flag bits not zero");
  a_rate_off_idle : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && state_q.pctl[6:4] == 3'h0 && !state_q.pctl[`RTCA_BIT_PEF]
     && !(i_wr && i_addr == `RTCA_OFF_PER_CTL)) |=> !state_q.pctl[`RTCA_BIT_PEF])
    else $error("periodic flag set while rate is zero");
  a_adj_reads_zero : assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd) && $past(i_addr) == `RTCA_OFF_PER_CTL && $past(i_ce)
    |-> o_rdata[2:1] == 2'b00)
    else $error("adjust or divider reset read back one");
  a_hold_stop : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !state_q.pctl[`RTCA_BIT_START] && !i_wr) |=> $stable(state_q.sec))
    else $error("seconds moved while halted");
endmodule : rtca_core

/* bench/rtc_alarm_flag_control_bench.sv */
// self-checking bench for the rtc alarm compare and flag control core
`include "rtca_defines.svh"
module rtc_alarm_flag_control_bench
  import rtca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // short tick keeps the two-second periodic case near a thousand cycles
  localparam int unsigned DIV = 4;
  typedef struct {
    rtca_addr_t a;
    rtca_byte_t w;
    rtca_byte_t m;
    rtca_byte_t e;
  } rtca_row_t;
  logic           i_clk;
  logic           i_rst;
  logic           i_ce;
  rtca_rst_kind_t i_rst_kind;
  rtca_addr_t     i_addr;
  rtca_byte_t     i_wdata;
  logic           i_wr;
  logic           i_rd;
  rtca_byte_t     o_rdata;
  rtca_byte_t     i_min_cnt;
  rtca_byte_t     i_hour_cnt;
  rtca_byte_t     i_wday_cnt;
  rtca_byte_t     i_date_cnt;
  rtca_byte_t     i_mon_cnt;
  logic           o_sec_carry;
  logic           o_min_inc;
  logic           o_count_run;
  logic           o_osc_run;
  logic           o_carry_irq;
  logic           o_alarm_irq;
  logic           o_period_irq;
  int             errors;
  int             comparisons;
  int             min_pulses;
  int             sec_pulses;
  int             n;
  int             m0;
  int             iv;
  rtca_row_t      rows [10] = '{
    '{`RTCA_OFF_SEC_ALM,  8'hd9, 8'hff, 8'hd9}, '{`RTCA_OFF_MIN_ALM, 8'ha5, 8'hff, 8'ha5},
    '{`RTCA_OFF_HOUR_ALM, 8'he3, 8'hff, 8'ha3}, '{`RTCA_OFF_WDAY_ALM, 8'hfe, 8'hff, 8'h86},
    '{`RTCA_OFF_DATE_ALM, 8'hf1, 8'hff, 8'hb1}, '{`RTCA_OFF_MON_ALM, 8'hf2, 8'hff, 8'h92},
    '{`RTCA_OFF_FLAG_CTL, 8'h7e, 8'h7e, 8'h18}, '{`RTCA_OFF_PER_CTL, 8'h0d, 8'h7f, 8'h09},
    '{`RTCA_OFF_PER_CTL,  8'h0b, 8'h7f, 8'h09}, '{4'hf, 8'h5a, 8'hff, 8'h00}};

  rtca_core #(.TICK_DIV(DIV)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_rst_kind(i_rst_kind),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_min_cnt(i_min_cnt), .i_hour_cnt(i_hour_cnt), .i_wday_cnt(i_wday_cnt),
    .i_date_cnt(i_date_cnt), .i_mon_cnt(i_mon_cnt), .o_sec_carry(o_sec_carry),
    .o_min_inc(o_min_inc), .o_count_run(o_count_run), .o_osc_run(o_osc_run),
    .o_carry_irq(o_carry_irq), .o_alarm_irq(o_alarm_irq), .o_period_irq(o_period_irq));

  always #5 i_clk = ~i_clk;

  always @(posedge i_clk)
    if (o_min_inc === 1'b1)
      min_pulses++;

  always @(posedge i_clk)
    if (o_sec_carry === 1'b1)
      sec_pulses++;

  task automatic conclude();
    $display("summary: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic check(input string name, input rtca_byte_t seen, input rtca_byte_t exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input rtca_addr_t a, input rtca_byte_t d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rdchk(input string name, input rtca_addr_t a, input rtca_byte_t m,
                       input rtca_byte_t e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check(name, o_rdata & m, e);
  endtask : rdchk

  task automatic reset_kind(input rtca_rst_kind_t k);
    @(posedge i_clk);
    i_rst      <= 1'b1;
    i_rst_kind <= k;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : reset_kind

  function automatic logic pick(input int w);
    return (w == 0) ? o_carry_irq : (w == 1) ? o_alarm_irq : o_period_irq;
  endfunction : pick

  task automatic wait_irq(input int w, input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++)
    begin
      @(posedge i_clk);
      #1;
      if (pick(w) === 1'b1)
        break;
    end
  endtask : wait_irq

  task automatic cnt_step(input rtca_byte_t from, input rtca_byte_t to);
    @(posedge i_clk);
    i_min_cnt <= from;
    @(posedge i_clk);
    i_min_cnt <= to;
    repeat (4) @(posedge i_clk);
  endtask : cnt_step

  initial
  begin
    #500000;
    errors++;
    $display("watchdog expired");
    conclude();
  end

  initial
  begin
    i_clk = 1'b0; i_rst = 1'b1; i_ce = 1'b1; i_rst_kind = RTCA_RST_POWER;
    i_addr = 4'h0; i_wdata = 8'h00; i_wr = 1'b0; i_rd = 1'b0;
    i_min_cnt = 8'h24; i_hour_cnt = 8'h10; i_wday_cnt = 8'h03;
    i_date_cnt = 8'h15; i_mon_cnt = 8'h06;
    errors = 0; comparisons = 0; min_pulses = 0; sec_pulses = 0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rdchk("flag_control", `RTCA_OFF_FLAG_CTL, 8'h7f, 8'h00);
    rdchk("period_control", `RTCA_OFF_PER_CTL, 8'hff, 8'h09);
    for (int i = 0; i < 6; i++)
      rdchk("compare_enable", 4'(i), 8'h80, 8'h00);
    check("run outputs", {6'h00, o_count_run, o_osc_run}, 8'h03);
    $display("done: power-on state");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rdchk("register readback", rows[i].a, rows[i].m, rows[i].e);
    end
    $display("done: register table");
    // minute and weekday armed, the other fields hold values that would not match
    wr(`RTCA_OFF_SEC_ALM, 8'h59); wr(`RTCA_OFF_MIN_ALM, 8'ha5); wr(`RTCA_OFF_HOUR_ALM, 8'h11);
    wr(`RTCA_OFF_WDAY_ALM, 8'h83); wr(`RTCA_OFF_DATE_ALM, 8'h16); wr(`RTCA_OFF_MON_ALM, 8'h07);
    wr(`RTCA_OFF_FLAG_CTL, 8'h08);
    rdchk("alarm flag idle", `RTCA_OFF_FLAG_CTL, 8'h01, 8'h00);
    @(posedge i_clk);
    i_min_cnt <= 8'h25;
    wait_irq(1, 4, n);
    check("alarm irq on match", {7'h00, n < 4}, 8'h01);
    wr(`RTCA_OFF_FLAG_CTL, 8'h09);
    rdchk("alarm flag write one", `RTCA_OFF_FLAG_CTL, 8'h01, 8'h01);
    wr(`RTCA_OFF_FLAG_CTL, 8'h08);
    rdchk("alarm flag write zero", `RTCA_OFF_FLAG_CTL, 8'h01, 8'h00);
    check("alarm irq released", {7'h00, o_alarm_irq}, 8'h00);
    i_wday_cnt <= 8'h04;
    cnt_step(8'h24, 8'h25);
    rdchk("weekday mismatch", `RTCA_OFF_FLAG_CTL, 8'h01, 8'h00);
    wr(`RTCA_OFF_FLAG_CTL, 8'h00);
    i_wday_cnt <= 8'h03;
    repeat (4) @(posedge i_clk);
    check("alarm irq masked", {7'h00, o_alarm_irq}, 8'h00);
    rdchk("alarm flag masked", `RTCA_OFF_FLAG_CTL, 8'h01, 8'h01);
    wr(`RTCA_OFF_MIN_ALM, 8'h25); wr(`RTCA_OFF_WDAY_ALM, 8'h03); wr(`RTCA_OFF_FLAG_CTL, 8'h08);
    cnt_step(8'h24, 8'h25);
    rdchk("no enables", `RTCA_OFF_FLAG_CTL, 8'h01, 8'h00);
    $display("done: alarm match");
    wr(`RTCA_OFF_FLAG_CTL, 8'h10);
    wait_irq(0, 2 * DIV + 4, n);
    check("carry irq", {7'h00, n < 2 * DIV + 4}, 8'h01);
    wr(`RTCA_OFF_FLAG_CTL, 8'h00);
    repeat (3 * DIV) @(posedge i_clk);
    check("carry irq masked", {7'h00, o_carry_irq}, 8'h00);
    rdchk("carry flag set", `RTCA_OFF_FLAG_CTL, 8'h80, 8'h80);
    // stopping the oscillator keeps ticks from setting the carry flag again while it is cleared
    wr(`RTCA_OFF_PER_CTL, 8'h01);
    wr(`RTCA_OFF_FLAG_CTL, 8'h00);
    rdchk("carry flag cleared", `RTCA_OFF_FLAG_CTL, 8'h80, 8'h00);
    repeat (4 * DIV) @(posedge i_clk);
    rdchk("oscillator halted", `RTCA_OFF_FLAG_CTL, 8'h80, 8'h00);
    check("osc run output", {7'h00, o_osc_run}, 8'h00);
    wr(`RTCA_OFF_PER_CTL, 8'h09);
    $display("done: carry flag");
    for (int c = 1; c < 8; c++)
    begin
      iv = (DIV / 2) << ((c < 5) ? 2 * c - 2 : c + 2);
      wr(`RTCA_OFF_PER_CTL, {1'b0, 3'(c), 4'h9});
      wait_irq(2, iv + 8, n);
      check("periodic set", {7'h00, n < iv + 8}, 8'h01);
      wr(`RTCA_OFF_PER_CTL, {1'b0, 3'(c), 4'h9});
      repeat (2) @(posedge i_clk);
      wait_irq(2, iv + 8, n);
      if (c > 1)
        check("periodic interval", {7'h00, n >= iv - 8 && n <= iv}, 8'h01);
    end
    wr(`RTCA_OFF_PER_CTL, 8'h09);
    wr(`RTCA_OFF_PER_CTL, 8'h09);
    repeat (40) @(posedge i_clk);
    check("periodic off", {7'h00, o_period_irq}, 8'h00);
    check("seconds carry seen", {7'h00, sec_pulses > 0}, 8'h01);
    $display("done: periodic rates");
    wr(`RTCA_OFF_PER_CTL, 8'h08);
    for (int k = 0; k < 2; k++)
    begin
      wr(`RTCA_OFF_SEC_CNT, (k == 0) ? 8'h30 : 8'h29);
      m0 = min_pulses;
      wr(`RTCA_OFF_PER_CTL, 8'h0c);
      repeat (3) @(posedge i_clk);
      check("minute carry", 8'(min_pulses - m0), (k == 0) ? 8'h01 : 8'h00);
      rdchk("seconds rounded", `RTCA_OFF_SEC_CNT, 8'h7f, 8'h00);
    end
    $display("done: thirty second round");
    wr(`RTCA_OFF_MIN_ALM, 8'ha5); wr(`RTCA_OFF_FLAG_CTL, 8'h18); wr(`RTCA_OFF_PER_CTL, 8'h30);
    reset_kind(RTCA_RST_MANUAL);
    rdchk("period manual", `RTCA_OFF_PER_CTL, 8'hff, 8'h00);
    check("run kept", {6'h00, o_count_run, o_osc_run}, 8'h00);
    check("irqs low", {5'h00, o_carry_irq, o_alarm_irq, o_period_irq}, 8'h00);
    rdchk("flag manual", `RTCA_OFF_FLAG_CTL, 8'h7f, 8'h00);
    rdchk("alarm manual", `RTCA_OFF_MIN_ALM, 8'hff, 8'ha5);
    wr(`RTCA_OFF_FLAG_CTL, 8'h18);
    reset_kind(RTCA_RST_NONE);
    rdchk("flag standby", `RTCA_OFF_FLAG_CTL, 8'h7f, 8'h18);
    rdchk("period standby", `RTCA_OFF_PER_CTL, 8'hff, 8'h00);
    rdchk("alarm standby", `RTCA_OFF_MIN_ALM, 8'hff, 8'ha5);
    reset_kind(RTCA_RST_POWER);
    rdchk("alarm power", `RTCA_OFF_MIN_ALM, 8'hff, 8'h25);
    rdchk("period power", `RTCA_OFF_PER_CTL, 8'hff, 8'h09);
    $display("done: reset kinds");
    conclude();
  end
endmodule : rtc_alarm_flag_control_bench
